// ### hw/pmc_power_ctrl.sv
// power modes, clock gating, mode register and idle bus pin states
`timescale 1ns/1ns
// Notes on behaviour
// - power-down gates both core and peripheral clocks
// - the power-down write is the last instruction before power-down
// - power-down stops oscillator and clocks, registers and memories kept
// - only supervisor reset (pin, brownout, debug, power-on) leaves power-down
// - no watchdog reset can occur in power-down
// - three-bit prescaler divides oscillator by 1 down to 1/2048
// - prescaler slows only core and watchdog clock, peripherals full rate
// - with auto-recover set, any interrupt forces prescaler to 000
// - idle keeps ports and peripherals, supervisor on, watchdog off
// - power-down holds ports, disables peripherals, supervisor, interrupts
// - low-power bus: strobe low, fetch/read/write high, address bytes FFh
// - bits 7 and 6 double baud rate of serial ports 0 and 1
// - bit 4 set by cold reset or by writing one, cleared by writing zero
// - bits 3 and 2 store serial port 1 receive/transmit clock selects
// - writing 1 to bit 1 enters power-down, 0 reads as not in it
// - writing 1 to bit 0 enters idle, 0 means not in idle
// - power control at address 87h, resets to 00h, bit 5 reserved
// - prescale codes: 1,2,4,8,16,32,1024,2048; change takes effect at once
// - idle gates only the core and watchdog clocks
// - any enabled interrupt clears the idle bit
// - supervisor reset clears mode bit, core restarts 3 machine cycles on; from power-down only after 4 oscillator settle cycles
module pmc_power_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic ext_reset_n,
  input wire logic brownout_detect,
  input wire logic debug_reset,
  input wire logic watchdog_expired,
  input wire logic irq_event,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic core_clk_en,
  output logic peripheral_clock_en,
  output logic watchdog_clk_en,
  output logic osc_enable,
  output logic core_hold,
  output logic supervisor_reset,
  output logic supervisor_enable,
  output logic peripherals_disable,
  output logic ext_int_enable,
  output logic ports_hold,
  output logic serial0_baud_double,
  output logic serial1_baud_double,
  output logic serial1_rx_clock_sel,
  output logic serial1_tx_clock_sel,
  output logic debug_cmp_enable,
  output logic [pmc_pkg::PMC_PS_W-1:0] core_prescale_select,
  output logic clock_auto_recover,
  output logic bus_override,
  output logic addr_latch_enable,
  output logic program_fetch_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] bus_ad_low,
  output logic [7:0] bus_addr_high
);
  import pmc_pkg::*;

  // pin-side inputs go through two flops first
  logic [1:0] ext_n_s_q;
  logic [1:0] bod_s_q;
  logic [1:0] dbg_s_q;
  logic [1:0] por_s_q;
  logic ext_n_s;
  logic bod_s;
  logic dbg_s;
  logic por_s;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_n_s_q <= 2'h3;
      bod_s_q <= 2'h0;
      dbg_s_q <= 2'h0;
      por_s_q <= 2'h0;
    end else begin
      ext_n_s_q <= {ext_n_s_q[0], ext_reset_n};
      bod_s_q <= {bod_s_q[0], brownout_detect};
      dbg_s_q <= {dbg_s_q[0], debug_reset};
      por_s_q <= {por_s_q[0], power_on_reset};
    end
  end
  assign ext_n_s = ext_n_s_q[1];
  assign bod_s = bod_s_q[1];
  assign dbg_s = dbg_s_q[1];
  assign por_s = por_s_q[1];

  pmc_mode_t mode_q;
  pmc_mode_t mode_d;
  logic [7:0] pctl_q;
  logic [7:0] pctl_d;
  logic [7:0] cctl_q;
  logic [7:0] cctl_d;
  // one bit wider than the counts so restart plus settle cannot wrap
  logic [4:0] wait_q;
  logic [4:0] wait_d;
  logic osc_on_q;
  logic osc_on_d;

  // only pin, brownout, debug and power-on resets; watchdog is dead in power-down
  logic sup_rst;
  logic wdt_rst;
  logic in_pd;
  logic in_idle;
  logic low_power;
  assign in_pd = (mode_q == PMC_PDOWN);
  assign in_idle = (mode_q == PMC_IDLE);
  assign low_power = in_pd || in_idle;
  assign wdt_rst = watchdog_expired && (mode_q == PMC_RUN);
  assign sup_rst = !ext_n_s || bod_s || dbg_s || por_s;

  // register decode
  logic pctl_sel;
  logic cctl_sel;
  logic pctl_wr;
  logic cctl_wr;
  assign pctl_sel = (sfr_addr == PMC_PCTL_ADDR);
  assign cctl_sel = (sfr_addr == PMC_CCTL_ADDR);
  // core is halted outside run, so it cannot write then
  assign pctl_wr = sfr_wr && pctl_sel && (mode_q == PMC_RUN);
  assign cctl_wr = sfr_wr && cctl_sel && (mode_q == PMC_RUN);
  assign sfr_hit = pctl_sel || cctl_sel;

  logic [7:0] pctl_wval;
  logic [7:0] mode_bits;
  assign mode_bits = (8'h01 << PMC_BIT_PD) | (8'h01 << PMC_BIT_IDLE);
  // power-down wins when both mode bits are written together
  assign pctl_wval = (sfr_wdata[PMC_BIT_PD]) ?
    (sfr_wdata & PMC_PCTL_WMASK & ~(8'h01 << PMC_BIT_IDLE)) :
    (sfr_wdata & PMC_PCTL_WMASK);

  always_comb begin
    pctl_d = pctl_q;
    if (pctl_wr) begin
      pctl_d = pctl_wval;
    end
    if (in_idle && irq_event) begin
      pctl_d[PMC_BIT_IDLE] = 1'b0;
    end
    if (sup_rst || wdt_rst) begin
      pctl_d = pctl_d & ~mode_bits;
    end
    if (por_s) begin
      pctl_d[PMC_BIT_COLD] = 1'b1;
    end
  end

  always_comb begin
    cctl_d = cctl_q;
    if (cctl_wr) begin
      cctl_d = sfr_wdata & PMC_CCTL_WMASK;
    end
    // interrupt wins over a same-cycle prescale write
    if (irq_event && cctl_q[PMC_BIT_AUTOREC]) begin
      cctl_d[PMC_PS_LSB +: PMC_PS_W] = PMC_PS_FULL;
    end
  end

  always_comb begin
    mode_d = mode_q;
    wait_d = wait_q;
    osc_on_d = osc_on_q;
    case (mode_q)
      PMC_RUN: begin
        if (pctl_wr && sfr_wdata[PMC_BIT_PD]) begin
          mode_d = PMC_PDOWN;
          osc_on_d = 1'b0;
        end else if (pctl_wr && sfr_wdata[PMC_BIT_IDLE]) begin
          mode_d = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (sup_rst) begin
          mode_d = PMC_WAKE;
          wait_d = 5'(PMC_RESTART_CYC);
        end else if (irq_event) begin
          mode_d = PMC_RUN;
        end
      end
      PMC_PDOWN: begin
        if (sup_rst) begin
          mode_d = PMC_WAKE;
          osc_on_d = 1'b1;
          wait_d = 5'(PMC_RESTART_CYC) + 5'(PMC_OSC_SETTLE_CYC);
        end
      end
      PMC_WAKE: begin
        // core waits for the reset source to drop, then counts down
        if (!sup_rst) begin
          if (wait_q == 5'h00) begin
            mode_d = PMC_RUN;
          end else begin
            wait_d = wait_q - 5'h01;
          end
        end
      end
      default: begin
        mode_d = PMC_RUN;
        osc_on_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= PMC_RUN;
      pctl_q <= PMC_PCTL_RESET;
      cctl_q <= PMC_CCTL_RESET;
      wait_q <= 5'h00;
      osc_on_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      pctl_q <= pctl_d;
      cctl_q <= cctl_d;
      wait_q <= wait_d;
      osc_on_q <= osc_on_d;
    end
  end

  // core clock enable: divided oscillator, stopped outside run
  logic core_run;
  logic core_tick;
  assign core_run = (mode_q == PMC_RUN);
  pmc_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(core_run),
    .sel(cctl_q[PMC_PS_LSB +: PMC_PS_W]),
    .tick(core_tick)
  );

  assign core_clk_en = core_tick;
  assign watchdog_clk_en = core_tick;
  // peripherals run undivided; only power-down and its wake stop them
  assign peripheral_clock_en = !in_pd && osc_on_q &&
    !(mode_q == PMC_WAKE && wait_q > 5'(PMC_RESTART_CYC));
  assign osc_enable = osc_on_q;
  assign core_hold = (mode_q == PMC_WAKE);
  assign supervisor_reset = sup_rst || wdt_rst;
  assign supervisor_enable = !in_pd;
  assign peripherals_disable = in_pd;
  assign ext_int_enable = !in_pd;
  assign ports_hold = low_power;

  assign serial0_baud_double = pctl_q[PMC_BIT_SERIAL0_BAUD_DOUBLE];
  assign serial1_baud_double = pctl_q[PMC_BIT_SERIAL1_BAUD_DOUBLE];
  assign serial1_rx_clock_sel = pctl_q[PMC_BIT_RXSEL];
  assign serial1_tx_clock_sel = pctl_q[PMC_BIT_TXSEL];
  assign debug_cmp_enable = cctl_q[PMC_BIT_DBGEN];
  assign core_prescale_select = cctl_q[PMC_PS_LSB +: PMC_PS_W];
  assign clock_auto_recover = cctl_q[PMC_BIT_AUTOREC];

  // bus pin states held in low-power modes; core drives them otherwise
  assign bus_override = low_power;
  assign addr_latch_enable = 1'b0;
  assign program_fetch_strobe_n = 1'b1;
  assign read_strobe_n = 1'b1;
  assign write_strobe_n = 1'b1;
  assign bus_ad_low = PMC_BUS_IDLE_BYTE;
  assign bus_addr_high = PMC_BUS_IDLE_BYTE;

  // read data registered one cycle after the read strobe
  logic [7:0] rdata_d;
  assign rdata_d = !sfr_rd ? 8'h00 :
                   pctl_sel ? pctl_q :
                   cctl_sel ? cctl_q : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end
endmodule : pmc_power_ctrl

// ### hw/pmc_pkg.sv
// constants for the power-mode controller
package pmc_pkg;
  localparam logic [7:0] PMC_PCTL_ADDR = 8'h87;
  localparam logic [7:0] PMC_CCTL_ADDR = 8'hF9;
  localparam logic [7:0] PMC_PCTL_RESET = 8'h00;
  localparam logic [7:0] PMC_CCTL_RESET = 8'h10;
  localparam logic [7:0] PMC_PCTL_WMASK = 8'hDF;
  localparam logic [7:0] PMC_CCTL_WMASK = 8'h1F;
  localparam int PMC_BIT_SERIAL0_BAUD_DOUBLE = 7;
  localparam int PMC_BIT_SERIAL1_BAUD_DOUBLE = 6;
  localparam int PMC_BIT_COLD = 4;
  localparam int PMC_BIT_RXSEL = 3;
  localparam int PMC_BIT_TXSEL = 2;
  localparam int PMC_BIT_PD = 1;
  localparam int PMC_BIT_IDLE = 0;
  localparam int PMC_BIT_DBGEN = 4;
  localparam int PMC_BIT_AUTOREC = 3;
  localparam int PMC_PS_LSB = 0;
  localparam int PMC_PS_W = 3;
  localparam int PMC_DIV_W = 11;
  localparam logic [2:0] PMC_PS_FULL = 3'h0;
  localparam logic [7:0] PMC_BUS_IDLE_BYTE = 8'hFF;
  // restart delay after supervisor reset, in machine cycles of 4 clocks
  localparam int PMC_RESTART_MC = 3;
  localparam int PMC_CLK_PER_MC = 4;
  localparam logic [3:0] PMC_RESTART_CYC =
    4'(PMC_RESTART_MC * PMC_CLK_PER_MC);
  // oscillator settle time before clocks reopen
  localparam logic [3:0] PMC_OSC_SETTLE_CYC = 4'h4;
  typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_PDOWN, PMC_WAKE}
    pmc_mode_t;
endpackage : pmc_pkg

// ### hw/pmc_prescaler.sv
// core clock enable divider selected by the prescale field
`timescale 1ns/1ns
module pmc_prescaler (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [pmc_pkg::PMC_PS_W-1:0] sel,
  output logic tick
);
  import pmc_pkg::*;
  logic [PMC_DIV_W-1:0] cnt_q;
  logic [PMC_DIV_W-1:0] cnt_d;
  logic [PMC_DIV_W-1:0] limit;

  // divisor minus one; a new select applies in the same cycle
  assign limit = (sel == 3'h0) ? 11'h000 :
                 (sel == 3'h1) ? 11'h001 :
                 (sel == 3'h2) ? 11'h003 :
                 (sel == 3'h3) ? 11'h007 :
                 (sel == 3'h4) ? 11'h00F :
                 (sel == 3'h5) ? 11'h01F :
                 (sel == 3'h6) ? 11'h3FF : 11'h7FF;
  assign tick = run && (cnt_q >= limit);
  assign cnt_d = !run ? cnt_q : (tick ? '0 : cnt_q + 11'h001);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : pmc_prescaler

// ### tb/pmc_power_ctrl_monitor.sv
// port assertions for the power-mode controller
`timescale 1ns/1ns
module pmc_power_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ext_reset_n,
  input wire logic brownout_detect,
  input wire logic debug_reset,
  input wire logic irq_event,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic core_clk_en,
  input wire logic peripheral_clock_en,
  input wire logic osc_enable,
  input wire logic core_hold,
  input wire logic supervisor_reset,
  input wire logic peripherals_disable,
  input wire logic ext_int_enable,
  input wire logic ports_hold,
  input wire logic [pmc_pkg::PMC_PS_W-1:0] core_prescale_select,
  input wire logic clock_auto_recover,
  input wire logic bus_override,
  input wire logic addr_latch_enable,
  input wire logic program_fetch_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] bus_ad_low,
  input wire logic [7:0] bus_addr_high
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // reset sources pass two sync flops, so history matters
  wire quiet = !brownout_detect && ext_reset_n && !debug_reset;
  wire pwr_wr = sfr_wr && sfr_addr == 8'h87 && !bus_override && !core_hold;
  property p_pd_off;
    !osc_enable |-> !core_clk_en && !peripheral_clock_en;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("clock with osc off");
  property p_core_per;
    core_clk_en |-> peripheral_clock_en;
  endproperty
  a_core_per: assert property (p_core_per)
    else $error("core without per");
  property p_idle;
    pwr_wr && sfr_wdata[1:0] == 2'b01 |=> !core_clk_en && peripheral_clock_en
      && bus_override && ports_hold;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle entry");
  property p_pd;
    pwr_wr && sfr_wdata[1] |=> !peripheral_clock_en && !osc_enable
      && peripherals_disable && !ext_int_enable;
  endproperty
  a_pd: assert property (p_pd)
    else $error("pd entry");
  property p_bus;
    bus_override |-> !addr_latch_enable && program_fetch_strobe_n
      && read_strobe_n && write_strobe_n && (bus_ad_low & bus_addr_high) == 8'hFF;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus pin state");
  property p_rec;
    irq_event && clock_auto_recover |=> core_prescale_select == 3'h0;
  endproperty
  a_rec: assert property (p_rec)
    else $error("no recovery");
  property p_idle_irq;
    bus_override && !peripherals_disable && !core_hold && irq_event
      |=> !bus_override;
  endproperty
  a_idle_irq: assert property (p_idle_irq)
    else $error("idle kept");
  property p_pd_stay;
    peripherals_disable && irq_event && quiet && $past(quiet)
      && $past(quiet, 2) |=> peripherals_disable;
  endproperty
  a_pd_stay: assert property (p_pd_stay)
    else $error("pd left");
  property p_no_wd;
    peripherals_disable && quiet && $past(quiet) && $past(quiet, 2)
      |-> !supervisor_reset;
  endproperty
  a_no_wd: assert property (p_no_wd)
    else $error("reset in pd");
  property p_osc;
    $rose(osc_enable) |-> !peripheral_clock_en ##1 !peripheral_clock_en;
  endproperty
  a_osc: assert property (p_osc)
    else $error("clock before osc");
  property p_unmap;
    sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped data");
endmodule : pmc_power_ctrl_monitor
bind pmc_power_ctrl pmc_power_ctrl_monitor pmc_power_ctrl_monitor_inst (.*);

// ### tb/pmc_core_model.sv
// core model issuing special-function register accesses
`timescale 1ns/1ns
module pmc_core_model (
  input wire logic sys_clk,
  input wire logic [7:0] sfr_rdata,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata
);
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
  endtask : rd
endmodule : pmc_core_model

// ### tb/pmc_power_ctrl_bench.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("Error %s exp %h got %h", nm, e, g); \
  end \
end
module pmc_power_ctrl_bench;
  import pmc_pkg::*;
  logic sys_clk, reset, power_on_reset, ext_reset_n, brownout_detect;
  logic debug_reset, watchdog_expired, irq_event, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bus_ad_low, bus_addr_high;
  logic sfr_hit, core_clk_en, peripheral_clock_en, watchdog_clk_en;
  logic osc_enable, core_hold, supervisor_reset, supervisor_enable;
  logic peripherals_disable, ext_int_enable, ports_hold, debug_cmp_enable;
  logic serial0_baud_double, serial1_baud_double, serial1_rx_clock_sel;
  logic serial1_tx_clock_sel, clock_auto_recover, bus_override;
  logic addr_latch_enable, program_fetch_strobe_n;
  logic read_strobe_n, write_strobe_n;
  logic [PMC_PS_W-1:0] core_prescale_select;
  logic [2:0] src = 3'h0;
  logic [7:0] rv;
  int fail_count, n_checks, cyc, cnt;
  int shift_tab [8] = '{0, 1, 2, 3, 4, 5, 10, 11};
  wire [3:0] ser = {serial0_baud_double, serial1_baud_double,
    serial1_rx_clock_sel, serial1_tx_clock_sel};
  wire [2:0] pd_st = {peripherals_disable, osc_enable, peripheral_clock_en};
  assign ext_reset_n = !src[0];
  assign brownout_detect = src[1];
  assign debug_reset = src[2];
  pmc_power_ctrl pmc_power_ctrl_inst (.*);
  pmc_core_model pmc_core_model_inst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pmc_core_model_inst.wr(a, d);
    // let the register update settle before anyone looks
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    pmc_core_model_inst.rd(a, rv);
    `CHK("rdata", e, rv & m)
  endtask : rdchk
  task automatic ticks(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (core_clk_en === 1'b1) begin
        cnt++;
      end
    end
  endtask : ticks
  task automatic pulse_irq();
    @(posedge sys_clk);
    irq_event <= 1'b1;
    @(posedge sys_clk);
    irq_event <= 1'b0;
  endtask : pulse_irq
  // hold long enough to pass the sync flops, then wait out the restart
  task automatic supv(input int s);
    int k;
    k = 0;
    @(posedge sys_clk);
    src <= 3'(1 << s);
    repeat (4) @(posedge sys_clk);
    src <= 3'h0;
    @(posedge sys_clk);
    while (core_hold !== 1'b0 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    `CHK("hold", 1'b0, core_hold)
    repeat (2) @(posedge sys_clk);
  endtask : supv
  initial begin
    reset = 1'b1;
    power_on_reset = 1'b0;
    watchdog_expired = 1'b0;
    irq_event = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdchk(8'h87, 8'hFF, 8'h00);
    rdchk(8'hF9, 8'hFF, 8'h10);
    `CHK("dbg", 1'b1, debug_cmp_enable)
    rdchk(8'h55, 8'hFF, 8'h00);
    power_on_reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    power_on_reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rdchk(8'h87, 8'hFF, 8'h10);
    wr(8'h87, 8'h00);
    rdchk(8'h87, 8'hFF, 8'h00);
    wr(8'h87, 8'hEC);
    rdchk(8'h87, 8'hFF, 8'hCC);
    `CHK("serial", 4'hF, ser)
    wr(8'h87, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr(8'hF9, 8'h10 | 8'(i));
      `CHK("sel", 3'(i), core_prescale_select)
      repeat (2048) @(posedge sys_clk);
      ticks(4096);
      `CHK("ticks", 4096 >> shift_tab[i], cnt)
    end
    wr(8'hF9, 8'h1B);
    pulse_irq();
    rdchk(8'hF9, 8'hFF, 8'h18);
    wr(8'hF9, 8'h13);
    pulse_irq();
    rdchk(8'hF9, 8'hFF, 8'h13);
    wr(8'hF9, 8'h10);
    $display("test prescaler done");
    wr(8'h87, 8'h01);
    wr(8'h87, 8'h80);
    ticks(16);
    `CHK("idle ticks", 0, cnt)
    `CHK("idle sup", 2'b11, {supervisor_enable, ports_hold})
    pulse_irq();
    rdchk(8'h87, 8'hFF, 8'h00);
    wr(8'h87, 8'h01);
    supv(1);
    rdchk(8'h87, 8'h13, 8'h00);
    $display("test idle done");
    for (int s = 0; s < 3; s++) begin
      wr(8'h87, 8'hC2);
      repeat (4) @(posedge sys_clk);
      `CHK("pd", 3'b100, pd_st)
      `CHK("pd en", 3'b010,
        {supervisor_enable, ports_hold, watchdog_clk_en})
      pulse_irq();
      watchdog_expired <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK("pd stay", 2'b10,
        {peripherals_disable, supervisor_reset})
      watchdog_expired <= 1'b0;
      supv(s);
      `CHK("wake", 3'b011, pd_st)
      rdchk(8'h87, 8'h13, 8'h00);
    end
    $display("test power-down done");
    final_report();
  end
endmodule : pmc_power_ctrl_bench
